// [src/ffp_pkg.sv]
// Constants for the flyback fault protection sequencer
package ffp_pkg;
  localparam int OVP_CYCLES      = 8;
  localparam int OTP_CYCLES      = 14;
  localparam int SDS_CYCLES      = 4;
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int OSC_TIME_MS     = 10;
  localparam longint OSC_TIME_PS = longint'(OSC_TIME_MS) * 1000000000;
  localparam int OSC_CYCLES      = int'((OSC_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int CNT_W           = 4;
  localparam int OSC_W           = 22;
  localparam int RECOVER_CYCLES  = 4;
  typedef enum logic [1:0] {
    FFP_RUN   = 2'b00,
    FFP_FAULT = 2'b01,
    FFP_WAIT  = 2'b11
  } ffp_state_t;
endpackage

// [src/ffp_cycle_counter.sv]
// Saturating per-event counter with terminal flag
module ffp_cycle_counter
  import ffp_pkg::*;
#(
  parameter int W      = 4,
  parameter int TARGET = 8
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Counting control
  input  wire logic         step,
  input  wire logic         clear,
  // Result
  output logic              reached
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_reached;

  // Elaboration check on the target
  if (TARGET < 1 || TARGET >= (1 << W)) begin : g_bad_target
    $error("ffp_cycle_counter: bad TARGET");
  end

  always_comb begin
    next_count   = count;
    next_reached = reached;
    if (clear) begin
      next_count   = '0;
      next_reached = 1'b0;
    end else if (step && !reached) begin
      next_count = count + W'(1);
      if (next_count == W'(TARGET)) begin
        next_reached = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count   <= '0;
      reached <= 1'b0;
    end else begin
      count   <= next_count;
      reached <= next_reached;
    end
  end
endmodule // ffp_cycle_counter

// [src/ffp_sequencer.sv]
// Fault protection sequencer top
// Contract
// - Aux overvoltage for 8 switching cycles halts gate, enters auto recovery.
// - Current sense above 0.2V in gate-off for 14 cycles: over-temperature fault.
// - Count cycles with current sense above 1.6V; fourth count turns gate off.
// - Aux below 0.7V during gate-off skips the next single switching cycle.
// - Comp above 2.6V over 10 ms with low supply stops gate drive.
// - Auto recovery resumes switching by itself once fault is gone.
module ffp_sequencer
  import ffp_pkg::*;
#(
  parameter int OSC_COUNT = OSC_CYCLES
) (
  // Clock and lockout reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Switching cycle timing
  input  wire logic cycle_start,
  input  wire logic gate_off_sample,
  input  wire logic gate_on_request,
  // Comparator results
  input  wire logic aux_overvoltage_trip,
  input  wire logic cs_over_temp_cmp,
  input  wire logic diode_short_trip,
  input  wire logic aux_undervoltage_cmp,
  input  wire logic loop_comp_high,
  input  wire logic supply_low_cmp,
  // Gate control and status
  output logic      gate_enable,
  output logic      aux_undervoltage_skip,
  output logic      over_temp_fault,
  output logic      output_short_trip,
  output logic      fault_active
);
  ffp_state_t state;
  ffp_state_t next_state;
  logic [OSC_W-1:0] osc_count;
  logic [OSC_W-1:0] next_osc_count;
  logic       osc_hit;
  logic       next_osc_hit;
  logic       skip_pending;
  logic       next_skip_pending;
  logic       next_skip;
  logic       next_gate_enable;
  logic       next_otp;
  logic       next_fault_active;
  logic [2:0] rec_count;
  logic [2:0] next_rec_count;
  logic       ovp_done;
  logic       otp_done;
  logic       sds_done;
  logic       any_fault;
  logic       fault_cond;
  logic       ovp_step;
  logic       ovp_clear;
  logic       otp_step;
  logic       otp_clear;
  logic       sds_step;
  logic       sds_clear;

  // Elaboration checks on timer and counter sizes
  if (OSC_COUNT < 1 || OSC_COUNT >= (1 << OSC_W)) begin : g_bad_osc_count
    $error("ffp_sequencer: bad OSC_COUNT");
  end
  if (RECOVER_CYCLES < 1 || RECOVER_CYCLES > 8) begin : g_bad_recover
    $error("ffp_sequencer: bad RECOVER_CYCLES");
  end
  if (OVP_CYCLES >= (1 << CNT_W) || OTP_CYCLES >= (1 << CNT_W)
      || SDS_CYCLES >= (1 << CNT_W)) begin : g_bad_cnt_w
    $error("ffp_sequencer: CNT_W too small for the persistence targets");
  end

  // Qualified strobes of the persistence counters
  assign ovp_step  = cycle_start && aux_overvoltage_trip;
  assign ovp_clear = cycle_start && !aux_overvoltage_trip;
  assign otp_step  = gate_off_sample && cs_over_temp_cmp;
  assign otp_clear = gate_off_sample && !cs_over_temp_cmp;
  assign sds_step  = cycle_start && diode_short_trip;
  assign sds_clear = cycle_start && !diode_short_trip;

  // Aux overvoltage persistence counter
  ffp_cycle_counter #(.W(CNT_W), .TARGET(OVP_CYCLES)) u_ovp (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .step    (ovp_step),
    .clear   (ovp_clear),
    .reached (ovp_done)
  );

  // Thermistor over-temperature counter, sampled in gate-off
  ffp_cycle_counter #(.W(CNT_W), .TARGET(OTP_CYCLES)) u_otp (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .step    (otp_step),
    .clear   (otp_clear),
    .reached (otp_done)
  );

  // Diode short counter, counts regardless of on-time length
  ffp_cycle_counter #(.W(CNT_W), .TARGET(SDS_CYCLES)) u_sds (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .step    (sds_step),
    .clear   (sds_clear),
    .reached (sds_done)
  );

  // Output short timer
  always_comb begin
    next_osc_count = osc_count;
    next_osc_hit   = osc_hit;
    if (!loop_comp_high) begin
      next_osc_count = '0;
      next_osc_hit   = 1'b0;
    end else if (osc_count != OSC_W'(OSC_COUNT)) begin
      next_osc_count = osc_count + OSC_W'(1);
    end else if (supply_low_cmp) begin
      next_osc_hit = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_count <= '0;
      osc_hit   <= 1'b0;
    end else begin
      osc_count <= next_osc_count;
      osc_hit   <= next_osc_hit;
    end
  end

  assign any_fault  = ovp_done || otp_done || sds_done || osc_hit;
  assign fault_cond = aux_overvoltage_trip || cs_over_temp_cmp || diode_short_trip
                      || osc_hit;

  // Protection state machine
  always_comb begin
    next_state     = state;
    next_rec_count = rec_count;
    case (state)
      FFP_RUN: begin
        if (any_fault) begin
          next_state = FFP_FAULT;
        end
      end
      FFP_FAULT: begin
        next_rec_count = '0;
        if (!fault_cond) begin
          next_state = FFP_WAIT;
        end
      end
      FFP_WAIT: begin
        if (fault_cond) begin
          next_state = FFP_FAULT;
        end else if (rec_count != 3'(RECOVER_CYCLES - 1)) begin
          next_rec_count = rec_count + 3'd1;
        end else if (!any_fault) begin
          next_state = FFP_RUN;
        end
      end
      default: begin
        next_state = FFP_FAULT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state     <= FFP_RUN;
      rec_count <= '0;
    end else begin
      state     <= next_state;
      rec_count <= next_rec_count;
    end
  end

  // Skip-one-cycle bookkeeping
  always_comb begin
    next_skip_pending = skip_pending;
    next_skip         = aux_undervoltage_skip;
    if (gate_off_sample && aux_undervoltage_cmp) begin
      next_skip_pending = 1'b1;
    end
    if (cycle_start) begin
      next_skip         = skip_pending;
      next_skip_pending = gate_off_sample && aux_undervoltage_cmp;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      skip_pending          <= 1'b0;
      aux_undervoltage_skip <= 1'b0;
    end else begin
      skip_pending          <= next_skip_pending;
      aux_undervoltage_skip <= next_skip;
    end
  end

  // Gate decision and status outputs
  always_comb begin
    next_fault_active = (next_state != FFP_RUN);
    next_otp          = otp_done;
    next_gate_enable  = gate_on_request && !next_fault_active && !any_fault
                        && !next_skip;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gate_enable       <= 1'b0;
      over_temp_fault   <= 1'b0;
      output_short_trip <= 1'b0;
      fault_active      <= 1'b0;
    end else begin
      gate_enable       <= next_gate_enable;
      over_temp_fault   <= next_otp;
      output_short_trip <= next_osc_hit;
      fault_active      <= next_fault_active;
    end
  end
endmodule // ffp_sequencer

// [tb/ffp_sequencer_properties.sv]
// Port checker of the fault sequencer, bound to its top
module ffp_sequencer_properties
  import ffp_pkg::*;
(
  // Watched ports
  input wire logic ref_clk, rst_n, cycle_start, gate_off_sample, gate_on_request,
  input wire logic aux_overvoltage_trip, cs_over_temp_cmp, diode_short_trip,
  input wire logic aux_undervoltage_cmp, loop_comp_high, supply_low_cmp, gate_enable,
  input wire logic aux_undervoltage_skip, over_temp_fault, output_short_trip, fault_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_FAULT_GATE: assert property (fault_active |-> !gate_enable)
    else $error("gate on in fault");
  AST_OTP_CAUSE: assert property ($rose(over_temp_fault) |->
    $past(gate_off_sample && cs_over_temp_cmp, 2)) else $error("bad temp fault");
  AST_FAULT_CAUSE: assert property ($rose(fault_active) |->
    $past(aux_overvoltage_trip || cs_over_temp_cmp || diode_short_trip || loop_comp_high, 2))
    else $error("fault without cause");
  AST_SKIP_END: assert property ($fell(aux_undervoltage_skip) |-> $past(cycle_start))
    else $error("skip end off cycle");
  AST_OSC_CAUSE: assert property ($rose(output_short_trip) |->
    $past(loop_comp_high && supply_low_cmp) ##[0:2] !gate_enable) else $error("bad short");
  AST_RECOVER: assert property ($fell(fault_active) && gate_on_request |->
    ##[1:40] gate_enable) else $error("no recovery");
  AST_LOCKOUT: assert property (!$past(rst_n) |->
    !fault_active && !gate_enable && !output_short_trip) else $error("out of lockout");
  AST_GATE_REQ: assert property (gate_enable |-> $past(gate_on_request))
    else $error("gate without request");
endmodule // ffp_sequencer_properties

bind ffp_sequencer ffp_sequencer_properties ffp_sequencer_properties_inst (.*);

// [tb/ffp_flyback_model.sv]
// Strobe and comparator model of the flyback stage
module ffp_flyback_model (
  // Clock and commanded faults
  input  wire logic       ref_clk,
  input  wire logic [5:0] fault_cmd,
  // Strobes, request and comparator levels
  output logic            cycle_start,
  output logic            gate_off_sample,
  output logic            gate_on_request,
  output logic [5:0]      cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase = 4'h0;
  initial {cycle_start, gate_off_sample, gate_on_request, cmp} = '0;
  always @(posedge ref_clk) begin
    phase <= phase + 4'h1;
    cycle_start <= phase == 4'hF;
    gate_off_sample <= phase == 4'h7;
    gate_on_request <= phase != 4'hB;
    if (phase == 4'hF) cmp <= fault_cmd;
  end
endmodule // ffp_flyback_model

// [tb/ffp_sequencer_tb.sv]
// Self-checking bench of the fault sequencer
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
module ffp_sequencer_tb;
  import ffp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, cycle_start, gate_off_sample, gate_on_request;
  logic aux_overvoltage_trip, cs_over_temp_cmp, diode_short_trip, aux_undervoltage_cmp;
  logic loop_comp_high, supply_low_cmp, gate_enable, aux_undervoltage_skip;
  logic over_temp_fault, output_short_trip, fault_active;
  logic [5:0] fault_cmd = '0, cmp;
  logic [15:0] lfsr = 16'h608C;
  int errors = 0, compares = 0, sel = 0, run_cnt = 0, osc_cnt = 0;
  localparam int OSC_SIM = 20;
  always #2 ref_clk = ~ref_clk;
  assign {supply_low_cmp, loop_comp_high, aux_undervoltage_cmp, diode_short_trip,
          cs_over_temp_cmp, aux_overvoltage_trip} = cmp;
  ffp_sequencer #(.OSC_COUNT(OSC_SIM)) ffp_sequencer_inst (.*);
  ffp_flyback_model ffp_flyback_model_inst (.*);
  always @(posedge ref_clk) begin
    if (sel == 1 ? gate_off_sample : cycle_start)
      run_cnt <= cmp[sel] ? run_cnt + 1 : 0;
    if (!output_short_trip) osc_cnt <= cmp[4] ? osc_cnt + 1 : 0;
  end
  function automatic int expect_count(input int b);
    return b == 0 ? OVP_CYCLES : b == 1 ? OTP_CYCLES : SDS_CYCLES;
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic settle(input logic v);
    for (int i = 0; i < 400 && v !== 1'b1; i++) @(negedge ref_clk);
  endtask
  task automatic recover();
    clk(1);
    fault_cmd <= '0;
    for (int i = 0; i < 200 && gate_enable !== 1'b1; i++) @(negedge ref_clk);
    `CHK({fault_active, gate_enable}, 2'b01)
  endtask
  task automatic fault_case(input int b);
    sel = b;
    lfsr = lfsr_next(lfsr);
    fault_cmd <= 6'h01 << b;
    clk(16 * (lfsr % 3 + 1));
    fault_cmd <= '0;
    clk(16);
    fault_cmd <= 6'h01 << b;
    for (int i = 0; i < 400 && fault_active !== 1'b1; i++) @(negedge ref_clk);
    `CHK(run_cnt, expect_count(b))
    `CHK({gate_enable, over_temp_fault}, {1'b0, b == 1})
    recover();
  endtask
  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk(20);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK({fault_active, gate_enable, output_short_trip}, 3'b000)
    clk(40);
    for (int k = 0; k < 6; k++) fault_case(k % 3);
    fault_cmd <= 6'h08;
    clk(16);
    fault_cmd <= '0;
    for (int i = 0; i < 64 && aux_undervoltage_skip !== 1'b1; i++) @(negedge ref_clk);
    for (int w = 0; w < 64; w++) begin
      if (aux_undervoltage_skip !== 1'b1) begin
        `CHK(w, 16)
        break;
      end
      `CHK(gate_enable, 1'b0)
      @(negedge ref_clk);
    end
    clk(1);
    fault_cmd <= 6'h20;
    clk(64);
    fault_cmd <= 6'h30;
    for (int i = 0; i < 200 && output_short_trip !== 1'b1; i++) @(negedge ref_clk);
    `CHK(osc_cnt, OSC_SIM + 1)
    recover();
    fault_cmd <= 6'h01;
    clk(80);
    rst_n <= 1'b0;
    clk(3);
    rst_n <= 1'b1;
    clk(96);
    @(negedge ref_clk);
    `CHK(fault_active, 1'b0)
    complete_run();
  end
  initial begin
    #100us;
    errors++;
    complete_run();
  end
endmodule // ffp_sequencer_tb
